// ---- rtl/pcpc_pipe_ctrl.v ----
// Contract
// R01: Drive the compliance pattern disparity control while the MAC requests compliance; the code holds it off while reverse loopback is selected.
// R02: Offer a selectable electrical idle inference from link activity instead of analog sensing.
// R03: Encode coding and analog status onto a three-bit receiver status code.
// R04: A detect request in P1 commands the transmit buffer to start receiver detection.
// R05: Keep the transmit buffer in electrical idle throughout P1; the MAC enters P1 only when idle.
// R06: The detect monitor needs a dedicated 125 MHz reference supplied from outside; the code times detect on the shared 10 MHz clk.
// R07: Report detection outcome with the one-bit PHY status and the three-bit status code.
// R08: Absorb up to 300 ppm offset with a rate match FIFO by adding or dropping skip symbols.
// R09: Reverse parallel loopback works only when configured for first-generation rate.
// R10: In loopback, rate-matched receive data goes back out the transmitter and still to the MAC.
// R11: A detect-or-loopback request in P0 selects reverse parallel loopback instead of detect.
// R12: No loopback other than reverse parallel loopback exists.
// R13: Bonded lanes share transmit clocking and control; the receiver keeps its own.
// R14: A single lane divides the borrowed serial clock locally into its parallel rate.
// R15: In P0s, P1 and P2 the only power saving is transmit electrical idle.
// R16: PHY status signals completion of detection and power state transitions.
// R17: On detect completion PHY status pulses one parallel cycle with the result alongside.
`timescale 1ns/1ps
`include "pcpc_consts.vh"
module pcpc_pipe_ctrl #(
    parameter PAR_DIV = `PCPC_PAR_DIV,
    parameter EI_CYC  = `PCPC_EI_CYC,
    parameter DET_CYC = `PCPC_DET_CYC,
    parameter DEPTH   = 8
) (
    input  wire       clk,             // 10 MHz clock
    input  wire       rst,             // Sync reset, active high
    input  wire       ser_clk_en,      // Serial clock tick from PLL channel
    input  wire       bond_en,         // Lane is a bonded slave
    input  wire       bond_tx_en,      // Shared tx parallel tick from master
    input  wire [1:0] bond_pd,         // Shared power state from master
    input  wire       gen1_cfg,        // Channel set up for first-gen rate
    input  wire       ei_infer_en,     // Use idle inference
    input  wire [1:0] powerdown,       // Requested power state
    input  wire       detect_loopback, // Detect or loopback request
    input  wire       tx_elecidle_req, // MAC idle request
    input  wire       tx_compliance,   // MAC compliance request
    input  wire [8:0] tx_sym,          // MAC symbol {k,data}
    input  wire [8:0] rx_sym,          // Aligned symbol {k,data}
    input  wire       rx_sym_valid,    // Symbol present
    input  wire       rx_dec_err,      // Decoder error
    input  wire       rx_disp_err,     // Disparity error
    input  wire       det_done_pin,    // Analog detect done
    input  wire       det_found_pin,   // Analog far end found
    input  wire       sig_det_pin,     // Analog signal detect
    output reg        tx_par_en,       // Tx parallel tick
    output reg        rx_par_en,       // Rx parallel tick
    output reg        rx_in_ready,     // Rate FIFO can take symbol
    output reg  [8:0] tx_out_sym,      // Symbol to serializer
    output reg        tx_force_disp,   // Compliance disparity control
    output reg        tx_idle,         // Tx buffer electrical idle
    output reg        det_start,       // Start detect pulse
    output reg        loopback_on,     // Reverse loopback active
    output reg  [8:0] rx_out_sym,      // Rate-matched symbol to MAC
    output reg        rx_out_valid,    // Symbol valid
    output reg        rx_elecidle,     // Receiver idle
    output reg        phystatus,       // Completion pulse
    output reg  [2:0] rxstatus         // Receiver status code
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_DONE = 2'h2;
    localparam [3:0] HI = `PCPC_RATE_HI;
    localparam [3:0] LO = `PCPC_RATE_LO;
    localparam [3:0] ST = `PCPC_RATE_START;

    function is_skp;
        input [8:0] s;
        begin
            is_skp = (s == `PCPC_SKP_SYM);
        end
    endfunction

    // Divider arithmetic shared by the tx and rx dividers
    function div_last;
        input [7:0] cnt;
        begin
            div_last = (cnt == PAR_DIV - 1);
        end
    endfunction

    function [7:0] div_step;
        input       wrap;
        input [7:0] cnt;
        begin
            div_step = wrap ? 8'h00 : cnt + 8'h01;
        end
    endfunction

    // =====================================================
    // Pin synchronisers
    reg  [2:0] s1;
    reg  [2:0] s2;
    reg  [2:0] s3;
    reg  [2:0] pin;
    wire [2:0] agree = ~(s2 ^ s3);

    always @(posedge clk)
    begin
        if (rst)
        begin
            s1  <= 3'h0;
            s2  <= 3'h0;
            s3  <= 3'h0;
            pin <= 3'h0;
        end
        else
        begin
            s1  <= {sig_det_pin, det_found_pin, det_done_pin};
            s2  <= s1;
            s3  <= s2;
            pin <= (s2 & agree) | (pin & ~agree);
        end
    end

    // =====================================================
    // Parallel clock enables
    reg  [7:0] tx_div;
    reg  [7:0] rx_div;
    wire       tx_wrap = ser_clk_en & div_last(tx_div);
    wire       rx_wrap = ser_clk_en & div_last(rx_div);
    wire       tx_tick = bond_en ? bond_tx_en : tx_wrap; // R13
    wire [1:0] pd      = bond_en ? bond_pd : powerdown;  // R13

    always @(posedge clk)
    begin
        if (rst)
        begin
            tx_div    <= 8'h00;
            rx_div    <= 8'h00;
            tx_par_en <= 1'b0;
            rx_par_en <= 1'b0;
        end
        else
        begin
            // Local divider on borrowed serial clock
            if (ser_clk_en)
                tx_div <= div_step(tx_wrap, tx_div); // R14
            // Receiver never follows the bonded master
            if (ser_clk_en)
                rx_div <= div_step(rx_wrap, rx_div); // R13
            tx_par_en <= tx_tick;
            rx_par_en <= rx_wrap;
        end
    end

    // =====================================================
    // Rate match FIFO
    // Address width follows the depth so a deeper FIFO needs no other edit
    localparam FIFO_AW = $clog2(DEPTH);
    wire [8:0] f_head;
    wire       f_valid;
    wire       f_wready;
    wire [FIFO_AW:0] f_level;
    wire       drop = is_skp(rx_sym) & (f_level >= HI);        // R08
    wire       wr   = rx_wrap & rx_sym_valid & ~drop;
    reg        primed;
    wire       hold = is_skp(f_head) & (f_level <= LO);        // R08
    wire       rd   = rx_wrap & primed & f_valid & ~hold;
    wire       ovf  = rx_wrap & rx_sym_valid & ~drop & ~f_wready;
    wire       unf  = rx_wrap & primed & ~f_valid;
    wire       rep  = primed & f_valid & hold;

    pcpc_fifo #(
        .WIDTH (`PCPC_SYM_W),
        .DEPTH (DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk      (clk),
        .rst      (rst),
        .wr_data  (rx_sym),
        .wr_valid (wr),
        .wr_ready (f_wready),
        .rd_data  (f_head),
        .rd_valid (f_valid),
        .rd_ready (rd),
        .level    (f_level)
    );

    // =====================================================
    // Detect and power state sequencing
    reg [1:0]  st;
    reg [15:0] tmr;
    reg [1:0]  pd_prev;
    reg        pd_pend;
    reg        req_prev;
    reg        found;
    wire       req_rise = detect_loopback & ~req_prev;

    always @(posedge clk)
    begin
        if (rst)
        begin
            st       <= ST_IDLE;
            tmr      <= 16'h0000;
            det_start<= 1'b0;
            req_prev <= 1'b0;
            found    <= 1'b0;
        end
        else
        begin
            req_prev  <= detect_loopback;
            det_start <= 1'b0;
            case (st)
                ST_IDLE:
                begin
                    if (req_rise & (pd == `PCPC_PD_P1))
                    begin
                        det_start <= 1'b1; // R04
                        tmr       <= 16'h0000;
                        st        <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    tmr <= tmr + 16'h0001;
                    // Timeout reports no receiver rather than hanging the MAC
                    if (pin[0] | (tmr == DET_CYC - 1))
                    begin
                        found <= pin[0] & pin[1];
                        st    <= ST_DONE;
                    end
                end
                ST_DONE:
                begin
                    if (tx_tick)
                        st <= ST_IDLE;
                end
                default:
                    st <= ST_IDLE;
            endcase
        end
    end

    // =====================================================
    // Transmit path and loopback
    wire lpbk = gen1_cfg & detect_loopback & (pd == `PCPC_PD_P0); // R09 R11 R12

    always @(posedge clk)
    begin
        if (rst)
        begin
            tx_out_sym    <= 9'h000;
            tx_force_disp <= 1'b0;
            tx_idle       <= 1'b1;
            loopback_on   <= 1'b0;
        end
        else
        begin
            loopback_on <= lpbk;
            if (tx_tick)
            begin
                tx_out_sym    <= lpbk ? f_head : tx_sym;                 // R10
                tx_force_disp <= tx_compliance & ~lpbk;                  // R01
                // Low power states only idle the buffer, nothing else
                tx_idle       <= tx_elecidle_req | (pd != `PCPC_PD_P0); // R05 R15
            end
            // P1 idles at once, without waiting for a tx tick
            else if (pd == `PCPC_PD_P1)
                tx_idle <= 1'b1; // R05
        end
    end

    // =====================================================
    // Receive output, idle and status
    reg [15:0] quiet;

    always @(posedge clk)
    begin
        if (rst)
        begin
            primed       <= 1'b0;
            rx_out_sym   <= 9'h000;
            rx_out_valid <= 1'b0;
            rx_elecidle  <= 1'b1;
            quiet        <= 16'h0000;
            pd_prev      <= `PCPC_PD_P1;
            pd_pend      <= 1'b0;
            phystatus    <= 1'b0;
            rxstatus     <= `PCPC_RS_OK;
        end
        else
        begin
            if (f_level >= ST)
                primed <= 1'b1;
            else if (~f_valid)
                primed <= 1'b0;
            if (rx_wrap)
            begin
                rx_out_valid <= rd | rep;
                rx_out_sym   <= f_head; // R10
                if (rx_sym_valid)
                    quiet <= 16'h0000;
                else if (quiet != EI_CYC)
                    quiet <= quiet + 16'h0001;
            end
            rx_elecidle <= ei_infer_en ? (quiet == EI_CYC) : ~pin[2]; // R02
            pd_prev <= pd;
            if (pd != pd_prev)
                pd_pend <= 1'b1;
            else if (tx_tick & (st != ST_DONE))
                pd_pend <= 1'b0;
            phystatus <= 1'b0;
            if (st == ST_DONE)
            begin
                if (tx_tick)
                begin
                    phystatus <= 1'b1; // R07 R16 R17
                    rxstatus  <= found ? `PCPC_RS_DETECTED : `PCPC_RS_OK; // R07 R17
                end
            end
            else if (tx_tick & pd_pend)
            begin
                phystatus <= 1'b1; // R16
                rxstatus  <= `PCPC_RS_OK;
            end
            else if (rx_wrap)
            begin
                // Completion status wins; below it decode error outranks the rest; skip events rank last
                if (rx_dec_err)
                    rxstatus <= `PCPC_RS_DEC_ERR; // R03
                else if (ovf)
                    rxstatus <= `PCPC_RS_OVERFLOW;
                else if (unf)
                    rxstatus <= `PCPC_RS_UNDERFLOW;
                else if (rx_disp_err)
                    rxstatus <= `PCPC_RS_DISP_ERR;
                else if (rep)
                    rxstatus <= `PCPC_RS_SKP_ADD;
                else if (rx_sym_valid & drop)
                    rxstatus <= `PCPC_RS_SKP_DEL;
                else
                    rxstatus <= `PCPC_RS_OK;
            end
        end
    end

    always @(posedge clk)
    begin
        if (rst)
            rx_in_ready <= 1'b1;
        else
            rx_in_ready <= f_wready;
    end
endmodule // pcpc_pipe_ctrl

// ---- rtl/pcpc_consts.vh ----
`ifndef PCPC_CONSTS_VH
`define PCPC_CONSTS_VH
// =====================================================
// Power states
`define PCPC_PD_P0        2'h0
`define PCPC_PD_P0S       2'h1
`define PCPC_PD_P1        2'h2
`define PCPC_PD_P2        2'h3
// =====================================================
// Receiver status codes
`define PCPC_RS_OK        3'h0
`define PCPC_RS_SKP_ADD   3'h1
`define PCPC_RS_SKP_DEL   3'h2
`define PCPC_RS_DETECTED  3'h3
`define PCPC_RS_DEC_ERR   3'h4
`define PCPC_RS_OVERFLOW  3'h5
`define PCPC_RS_UNDERFLOW 3'h6
`define PCPC_RS_DISP_ERR  3'h7
// =====================================================
// Symbols and fields
`define PCPC_SKP_SYM      9'h11c
`define PCPC_SYM_W        9
`define PCPC_RATE_HI      4'h6
`define PCPC_RATE_LO      4'h2
`define PCPC_RATE_START   4'h4
// =====================================================
// Timing
`define PCPC_CLK_PERIOD_NS 100
`define PCPC_EI_TIME_NS    16000
`define PCPC_DET_TMO_NS    10000
`define PCPC_EI_CYC   ((`PCPC_EI_TIME_NS + `PCPC_CLK_PERIOD_NS - 1) / `PCPC_CLK_PERIOD_NS)
`define PCPC_DET_CYC  (`PCPC_DET_TMO_NS / `PCPC_CLK_PERIOD_NS)
`define PCPC_PAR_DIV  2
`endif

// ---- rtl/pcpc_fifo.v ----
`timescale 1ns/1ps
module pcpc_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk,       // Clock
    input  wire             rst,       // Sync reset
    input  wire [WIDTH-1:0] wr_data,   // Write data
    input  wire             wr_valid,  // Write request
    output reg              wr_ready,  // Not full
    output reg  [WIDTH-1:0] rd_data,   // Registered head
    output reg              rd_valid,  // Head valid
    input  wire             rd_ready,  // Pop head
    output reg  [AW:0]      level      // Words held incl. head
);
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wptr;
    reg  [AW-1:0]    rptr;
    reg  [AW:0]      cnt;
    wire             do_wr = wr_valid & wr_ready;
    wire             load  = (cnt != {(AW+1){1'b0}}) & (~rd_valid | rd_ready);
    wire             pop   = rd_valid & rd_ready;
    wire [AW:0]      next_cnt = cnt + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, load};

    always @(posedge clk)
    begin
        if (do_wr)
            mem[wptr] <= wr_data;
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            wptr     <= {AW{1'b0}};
            rptr     <= {AW{1'b0}};
            cnt      <= {(AW+1){1'b0}};
            rd_valid <= 1'b0;
            rd_data  <= {WIDTH{1'b0}};
            wr_ready <= 1'b1;
            level    <= {(AW+1){1'b0}};
        end
        else
        begin
            if (do_wr)
                wptr <= wptr + {{(AW-1){1'b0}}, 1'b1};
            if (load)
            begin
                rptr    <= rptr + {{(AW-1){1'b0}}, 1'b1};
                rd_data <= mem[rptr];
            end
            if (load)
                rd_valid <= 1'b1;
            else if (pop)
                rd_valid <= 1'b0;
            cnt      <= next_cnt;
            // One slot kept back so the head register never stalls a write
            wr_ready <= (next_cnt < DEPTH - 1);
            level    <= next_cnt + {{AW{1'b0}}, (load | (rd_valid & ~pop))};
        end
    end
endmodule // pcpc_fifo

// ---- testbench/pcpc_chk_sva.sv ----
`timescale 1ns/1ps
`include "pcpc_consts.vh"
module pcpc_chk #(
    parameter EI_CYC = 8
) (
    input wire       clk,             // Clock
    input wire       rst,             // Reset
    input wire       bond_en,         // Bonded lane
    input wire [1:0] powerdown,       // Power state
    input wire       detect_loopback, // Request
    input wire       tx_elecidle_req, // Idle request
    input wire       tx_compliance,   // Compliance
    input wire       gen1_cfg,        // Gen1 rate
    input wire       ei_infer_en,     // Inference on
    input wire       rx_sym_valid,    // Rx valid
    input wire       rx_dec_err,      // Decode error
    input wire       det_start,       // Detect start
    input wire       phystatus,       // Completion
    input wire       tx_idle,         // Tx idle
    input wire       loopback_on,     // Loopback
    input wire       tx_force_disp,   // Disparity
    input wire       rx_elecidle,     // Rx idle
    input wire [2:0] rxstatus         // Status
);
    localparam int QUIET = 2 * EI_CYC + 8;
    reg [15:0] quiet;
    // ========================================
    // Quiet counter, saturates so it never wraps to zero
    always @(posedge clk)
        if (rst || !ei_infer_en || rx_sym_valid)
            quiet <= 16'h0;
        else if (quiet != 16'hffff)
            quiet <= quiet + 16'h1;
    // ========================================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_tx_off;
        (tx_elecidle_req || powerdown != `PCPC_PD_P0) && !bond_en;
    endsequence
    sequence s_tx_on;
        !tx_elecidle_req && powerdown == `PCPC_PD_P0 && !bond_en;
    endsequence
    sequence s_not_p0;
        powerdown != `PCPC_PD_P0 && !bond_en;
    endsequence
    sequence s_det_req;
        det_start ##1 !det_start;
    endsequence
    a_tx_idle_held:
        assert property (s_tx_off [*6] |-> tx_idle) else $error("tx not idle");
    a_tx_active:
        assert property (s_tx_on [*6] |-> !tx_idle) else $error("tx idle in P0");
    a_det_origin:
        assert property (det_start |-> $past(powerdown) == `PCPC_PD_P1)
            else $error("detect outside P1");
    a_det_answer:
        assert property (s_det_req |-> ##[0:40] phystatus) else $error("no detect end");
    a_phy_pulse:
        assert property (phystatus |=> !phystatus) else $error("phystatus too long");
    a_loop_gen1:
        assert property ((!gen1_cfg) [*6] |-> !loopback_on) else $error("loop w/o gen1");
    a_loop_p0:
        assert property (s_not_p0 [*6] |-> !loopback_on) else $error("loop outside P0");
    a_compliance_disp:
        assert property ((tx_compliance && !detect_loopback) [*6] |-> tx_force_disp)
            else $error("no disparity control");
    a_dec_status:
        assert property ((rx_dec_err && rx_sym_valid) [*4] |-> ##[0:6]
            rxstatus == `PCPC_RS_DEC_ERR) else $error("decode status missing");
    a_idle_infer:
        assert property (quiet >= QUIET |-> rx_elecidle) else $error("idle not inferred");
endmodule // pcpc_chk

// ---- testbench/pcpc_far_model.sv ----
`timescale 1ns/1ps
module pcpc_far_model (
    input  wire       clk,           // Clock
    input  wire       det_start,     // Detect command
    input  wire       found,         // Far receiver present
    input  wire       link_on,       // Line energy present
    input  wire [7:0] delay,         // Settle time in cycles
    output reg        det_done_pin,  // Detect done
    output reg        det_found_pin, // Receiver found
    output wire       sig_det_pin    // Signal detect
);
    assign sig_det_pin = link_on;
    // ========================================
    // Analog detect answer, held long enough to cross the sync flops
    initial
    begin
        det_done_pin = 1'b0;
        det_found_pin = 1'b0;
        forever
        begin
            do @(posedge clk); while (det_start !== 1'b1);
            repeat (delay) @(negedge clk);
            @(negedge clk);
            det_done_pin = 1'b1;
            det_found_pin = found;
            repeat (4) @(negedge clk);
            det_done_pin = 1'b0;
            det_found_pin = 1'b0;
        end
    end
endmodule // pcpc_far_model

// ---- testbench/pcpc_pipe_ctrl_test.sv ----
`timescale 1ns/1ps
`include "pcpc_consts.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end
module pcpc_pipe_ctrl_test;
    reg        clk, rst, gen1_cfg, ei_infer_en, detect_loopback, tx_elecidle_req;
    reg        tx_compliance, rx_sym_valid, rx_dec_err, rx_disp_err, found, link_on;
    reg  [1:0] powerdown;
    reg  [8:0] rx_sym, tx_sym;
    reg  [7:0] delay;
    reg        bond_en, bond_tx_en;
    reg  [1:0] bond_pd;
    reg  [2:0] ex;
    reg [31:0] r;
    wire       det_done_pin, det_found_pin, sig_det_pin, tx_par_en, rx_par_en;
    wire       rx_in_ready, tx_force_disp, tx_idle, det_start, loopback_on;
    wire       rx_out_valid, rx_elecidle, phystatus;
    wire [8:0] tx_out_sym, rx_out_sym;
    wire [2:0] rxstatus;
    integer    bad_count, checked, seed, outs, tx_n, rx_n;
    reg  [2:0] expq[$];
    bit        seen[bit [8:0]];
    // Serial tick tied high: dividers advance every clock
    pcpc_pipe_ctrl #(.EI_CYC(8), .DET_CYC(10)) pcpc_pipe_ctrl_inst (.clk, .rst,
        .ser_clk_en(1'b1), .bond_en, .bond_tx_en, .bond_pd, .gen1_cfg,
        .ei_infer_en, .powerdown, .detect_loopback, .tx_elecidle_req, .tx_compliance,
        .tx_sym, .rx_sym, .rx_sym_valid, .rx_dec_err, .rx_disp_err, .det_done_pin,
        .det_found_pin, .sig_det_pin, .tx_par_en, .rx_par_en, .rx_in_ready, .tx_out_sym,
        .tx_force_disp, .tx_idle, .det_start, .loopback_on, .rx_out_sym, .rx_out_valid,
        .rx_elecidle, .phystatus, .rxstatus);
    pcpc_far_model pcpc_far_model_inst (.clk, .det_start, .found, .link_on, .delay,
        .det_done_pin, .det_found_pin, .sig_det_pin);
    // ========================================
    // Clock, watchdog and completion scoreboard
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        #2000000;
        bad_count++;
        results;
    end
    always @(negedge clk)
        if (!rst && phystatus === 1'b1)
        begin
            ex = (expq.size() != 0) ? expq.pop_front() : 3'bx;
            `CHK("rxstatus", ex, rxstatus)
        end
    // ========================================
    // Tasks
    task tick(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task ticks(input integer n);
        repeat (n)
        begin
            tick(1);
            bond_tx_en = 1'b0;
            tx_n = tx_n + tx_par_en;
            rx_n = rx_n + rx_par_en;
        end
    endtask
    task results;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task drain;
        integer k;
        k = 0;
        while (expq.size() != 0 && k < 200)
        begin
            tick(1);
            k++;
        end
        if (expq.size() != 0)
        begin
            bad_count++;
            results;
        end
    endtask
    task det(input f, input [7:0] d, input [2:0] e);
        found = f;
        delay = d;
        expq.push_back(e);
        detect_loopback = 1'b1;
        tick(4);
        `CHK("loop_in_p1", 1'b0, loopback_on)
        detect_loopback = 1'b0;
        drain;
        tick(d + 8);
    endtask
    task pwr(input [1:0] p);
        expq.push_back(`PCPC_RS_OK);
        tx_elecidle_req = (p == `PCPC_PD_P1);
        powerdown = p;
        drain;
        tick(4);
        `CHK("tx_idle", p != `PCPC_PD_P0, tx_idle)
    endtask
    task stream(input integer n);
        repeat (n)
        begin
            r = $random(seed);
            rx_sym = {1'b0, r[7:0]};
            tx_sym = r[16:8];
            seen[rx_sym] = 1'b1;
            rx_sym_valid = 1'b1;
            tick(1);
            if (rx_out_valid === 1'b1)
                outs++;
        end
    endtask
    // ========================================
    // Main sequence
    initial
    begin
        seed = 32'hbb25;
        {bad_count, checked, outs} = 0;
        {gen1_cfg, ei_infer_en, detect_loopback, tx_compliance, found} = 5'h0;
        {bond_en, bond_tx_en, bond_pd} = 4'h0;
        {rx_sym_valid, rx_dec_err, rx_disp_err, rx_sym, tx_sym, delay} = 29'h0;
        {rst, link_on, tx_elecidle_req} = 3'h7;
        powerdown = `PCPC_PD_P1;
        repeat (4) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        tick(2);
        det(1'b1, 8'h02, `PCPC_RS_DETECTED);
        det(1'b0, 8'h02, `PCPC_RS_OK);
        det(1'b1, 8'h1e, `PCPC_RS_OK);
        det(1'b1, 8'h00, `PCPC_RS_DETECTED);
        pwr(`PCPC_PD_P0);
        pwr(`PCPC_PD_P0S);
        pwr(`PCPC_PD_P2);
        pwr(`PCPC_PD_P1);
        pwr(`PCPC_PD_P0);
        detect_loopback = 1'b1;
        stream(8);
        `CHK("loop_no_gen1", 1'b0, loopback_on)
        gen1_cfg = 1'b1;
        stream(24);
        `CHK("loop_on", 1'b1, loopback_on)
        `CHK("loop_sym", 1'b1, seen.exists(tx_out_sym))
        `CHK("rx_out", 1'b1, outs > 0)
        `CHK("rx_sym_seen", 1'b1, seen.exists(rx_out_sym))
        `CHK("rx_ready", 1'b1, rx_in_ready)
        detect_loopback = 1'b0;
        tx_compliance = 1'b1;
        tick(8);
        `CHK("disp_on", 1'b1, tx_force_disp)
        tx_compliance = 1'b0;
        tick(8);
        `CHK("disp_off", 1'b0, tx_force_disp)
        rx_dec_err = 1'b1;
        stream(8);
        `CHK("dec_err", `PCPC_RS_DEC_ERR, rxstatus)
        rx_disp_err = 1'b1;
        stream(8);
        `CHK("both_err", `PCPC_RS_DEC_ERR, rxstatus)
        rx_dec_err = 1'b0;
        stream(8);
        `CHK("disp_err", `PCPC_RS_DISP_ERR, rxstatus)
        rx_disp_err = 1'b0;
        // Fill the FIFO with skips so the drain ends in a repeated head
        rx_sym = `PCPC_SKP_SYM;
        tick(16);
        ei_infer_en = 1'b1;
        rx_sym_valid = 1'b0;
        tick(28);
        `CHK("idle_inferred", 1'b1, rx_elecidle)
        `CHK("skp_add", `PCPC_RS_SKP_ADD, rxstatus)
        stream(8);
        `CHK("idle_left", 1'b0, rx_elecidle)
        {ei_infer_en, link_on, rx_sym_valid} = 3'h0;
        tick(8);
        `CHK("idle_analog", 1'b1, rx_elecidle)
        {tx_n, rx_n} = 0;
        ticks(16);
        `CHK("tx_rate", 16 / `PCPC_PAR_DIV, tx_n)
        `CHK("rx_rate", 16 / `PCPC_PAR_DIV, rx_n)
        // Bonded: tx tick and power state come from the master lane
        bond_pd = `PCPC_PD_P2;
        bond_en = 1'b1;
        expq.push_back(`PCPC_RS_OK);
        {tx_n, rx_n} = 0;
        repeat (4)
        begin
            bond_tx_en = 1'b1;
            ticks(4);
        end
        drain;
        `CHK("bond_tx_rate", 4, tx_n)
        `CHK("bond_rx_rate", 8, rx_n)
        `CHK("bond_tx_idle", 1'b1, tx_idle)
        results;
    end
endmodule // pcpc_pipe_ctrl_test
bind pcpc_pipe_ctrl pcpc_chk #(.EI_CYC(EI_CYC)) pcpc_chk_inst (.clk, .rst, .bond_en,
    .powerdown, .detect_loopback, .tx_elecidle_req, .tx_compliance, .gen1_cfg, .ei_infer_en,
    .rx_sym_valid, .rx_dec_err, .det_start, .phystatus, .tx_idle, .loopback_on,
    .tx_force_disp, .rx_elecidle, .rxstatus);
